// >>> design/mtg_pkg.sv
// Package for the memory controller tick generator: ratios, tick positions, carriers
package mtg_pkg;

  // ****************************************
  // Ratio select codes (bus : core)
  // ****************************************
  localparam logic [2:0] MTG_RATIO_1_3 = 3'h0;
  localparam logic [2:0] MTG_RATIO_1_4 = 3'h1;
  localparam logic [2:0] MTG_RATIO_1_5 = 3'h2;
  localparam logic [2:0] MTG_RATIO_1_6 = 3'h3;
  localparam logic [2:0] MTG_RATIO_1_8 = 3'h4;
  localparam logic [2:0] MTG_RATIO_1_10 = 3'h5;
  localparam logic [2:0] MTG_RATIO_RST = MTG_RATIO_1_4;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int MTG_MC_SIGS = 4;    // Programmable / chip-select outputs
  localparam int MTG_SDRAM_W = 8;    // Synchronous DRAM outputs
  localparam int MTG_BUS_W = 8;      // Other bus outputs
  localparam int MTG_STEPS_PER_CORE = 2; // Each ref_clk cycle is half a core cycle
  localparam logic [4:0] MTG_CNT_RST = 5'h00;

  // Step positions inside one reference period, first tick at step 0
  localparam int MTG_R3_T2 = MTG_STEPS_PER_CORE * 3 * 1 / 6;
  localparam int MTG_R3_T4 = MTG_STEPS_PER_CORE * 3 * 4 / 6;
  localparam int MTG_R5_T2 = MTG_STEPS_PER_CORE * 5 * 2 / 10;
  localparam int MTG_R5_T4 = MTG_STEPS_PER_CORE * 5 * 7 / 10;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [4:0] last; // Final step of the period
    logic [4:0] t2;
    logic [4:0] t3;
    logic [4:0] t4;
  } mtg_pos_t;

  // Tick choice per programmable output: 0 first .. 3 fourth
  typedef logic [MTG_MC_SIGS-1:0][1:0] mtg_mc_sel_t;

  // Core cycles per reference period for a ratio code, illegal codes act as 1:4
  function automatic int mtg_core_per_ref(input logic [2:0] r);
    unique case (r)
      MTG_RATIO_1_3: return 3;
      MTG_RATIO_1_5: return 5;
      MTG_RATIO_1_6: return 6;
      MTG_RATIO_1_8: return 8;
      MTG_RATIO_1_10: return 10;
      default: return 4;
    endcase
  endfunction : mtg_core_per_ref

  // Tick step positions for a ratio code
  function automatic mtg_pos_t mtg_positions(input logic [2:0] r);
    int n;
    mtg_pos_t p;
    n = MTG_STEPS_PER_CORE * mtg_core_per_ref(r);
    p.last = 5'(n - 1);
    p.t3 = 5'(n / 2);
    if (r == MTG_RATIO_1_3)
    begin
      p.t2 = 5'(MTG_R3_T2);
      p.t4 = 5'(MTG_R3_T4);
    end
    else if (r == MTG_RATIO_1_5)
    begin
      p.t2 = 5'(MTG_R5_T2);
      p.t4 = 5'(MTG_R5_T4);
    end
    else
    begin
      p.t2 = 5'(n / 4);
      p.t4 = 5'(3 * n / 4);
    end
    return p;
  endfunction : mtg_positions

  // Whole state of the generator
  typedef struct packed {
    logic [4:0] cnt;
    logic [2:0] ratio;
    logic [3:0] ticks;     // bit0 first .. bit3 fourth
    logic ref_level;
    logic [MTG_MC_SIGS-1:0] mc;
    logic [MTG_SDRAM_W-1:0] sdram;
    logic [MTG_BUS_W-1:0] bus;
  } mtg_state_t;

endpackage : mtg_pkg

// >>> design/mtg_tick_gen.sv
// Memory controller tick generator with tick-timed output stages
// Notes on behaviour
// - Bus outputs launch on reference rising edge
// - Four ticks divide every reference period
// - First tick rising edge, third falling edge
// - Ratios 1:4, 1:6, 1:8, 1:10: ticks at 1/4, 3/4
// - Ratio 1:3: ticks at 1/6, 4/6
// - Ratio 1:5: ticks at 2/10, 7/10
// - Programmable machines change on configured tick
// - SDRAM outputs change on rising edge only
`timescale 1ns/1ps
module mtg_tick_gen
  import mtg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] ratio_sel,
  input wire mtg_mc_sel_t mc_sel,
  input wire logic [MTG_MC_SIGS-1:0] mc_d,
  input wire logic [MTG_SDRAM_W-1:0] sdram_d,
  input wire logic [MTG_BUS_W-1:0] bus_d,
  output logic tick_first,
  output logic tick_second,
  output logic tick_third,
  output logic tick_fourth,
  output logic reference_clock,
  output logic [2:0] ratio_active,
  output logic [MTG_MC_SIGS-1:0] mc_q,
  output logic [MTG_SDRAM_W-1:0] sdram_q,
  output logic [MTG_BUS_W-1:0] bus_q
);

  // ****************************************
  // State
  // ****************************************
  mtg_state_t st_q;
  mtg_state_t st_d;
  mtg_pos_t pos_q;
  mtg_pos_t pos_d;
  logic ratio_ok;

  localparam mtg_state_t ST_RST = '{
    cnt: MTG_CNT_RST,
    ratio: MTG_RATIO_RST,
    ticks: 4'h1,
    ref_level: 1'b1,
    mc: '0,
    sdram: '0,
    bus: '0
  };

  // Legal ratio codes
  assign ratio_ok = (ratio_sel <= MTG_RATIO_1_10);

  // Positions for the ratio in force now
  assign pos_q = mtg_positions(st_q.ratio);

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_d = st_q;
    // Step counter, wraps once per reference period
    if (st_q.cnt >= pos_q.last)
      st_d.cnt = MTG_CNT_RST;
    else
      st_d.cnt = st_q.cnt + 5'h01;
    // New ratio taken only at a period boundary; illegal codes keep the old one
    if (st_d.cnt == MTG_CNT_RST && ratio_ok)
      st_d.ratio = ratio_sel;
    // Positions of the coming cycle, worked out in this process so that the
    // next state never loops back on itself through a separate net
    pos_d = mtg_positions(st_d.ratio);
    // Tick strobes at the ratio's step positions
    st_d.ticks[0] = (st_d.cnt == MTG_CNT_RST);
    st_d.ticks[1] = (st_d.cnt == pos_d.t2);
    st_d.ticks[2] = (st_d.cnt == pos_d.t3);
    st_d.ticks[3] = (st_d.cnt == pos_d.t4);
    // Reference clock high in first half of the period
    st_d.ref_level = (st_d.cnt < pos_d.t3);
    // Bus and SDRAM outputs launch on the rising edge only
    if (st_d.ticks[0])
    begin
      st_d.bus = bus_d;
      st_d.sdram = sdram_d;
    end
    // Programmable outputs launch on their own selected tick
    // Each one holds its value until its own tick comes round
    for (int i = 0; i < MTG_MC_SIGS; i++)
    begin
      if (st_d.ticks[mc_sel[i]])
        st_d.mc[i] = mc_d[i];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Synchronous reset parks the generator at a period start
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  // Outputs straight from the state register
  assign tick_first = st_q.ticks[0];
  assign tick_second = st_q.ticks[1];
  assign tick_third = st_q.ticks[2];
  assign tick_fourth = st_q.ticks[3];
  assign reference_clock = st_q.ref_level;
  assign ratio_active = st_q.ratio;
  assign mc_q = st_q.mc;
  assign sdram_q = st_q.sdram;
  assign bus_q = st_q.bus;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_T1_ON_RISE: assert property ($rose(reference_clock) |-> tick_first)
    else $error("first tick missing at reference rise");
  AST_T3_ON_FALL: assert property ($fell(reference_clock) |-> tick_third)
    else $error("third tick missing at reference fall");
  AST_ONE_TICK: assert property ($onehot0({tick_first, tick_second, tick_third, tick_fourth}))
    else $error("more than one tick at once");
  AST_BUS_ON_RISE: assert property ($changed(bus_q) |-> tick_first)
    else $error("bus output changed off the rising edge");
  AST_SDRAM_ON_RISE: assert property ($changed(sdram_q) |-> tick_first)
    else $error("sdram output changed off the rising edge");
  AST_R4_SPACING: assert property (tick_first && ratio_active == MTG_RATIO_1_4 |->
      ##2 tick_second ##2 tick_third ##2 tick_fourth ##2 tick_first)
    else $error("wrong tick spacing at ratio 1:4");
  AST_R3_SPACING: assert property (tick_first && ratio_active == MTG_RATIO_1_3 |->
      ##1 tick_second ##2 tick_third ##1 tick_fourth ##2 tick_first)
    else $error("wrong tick spacing at ratio 1:3");
  AST_R5_SPACING: assert property (tick_first && ratio_active == MTG_RATIO_1_5 |->
      ##2 tick_second ##3 tick_third ##2 tick_fourth ##3 tick_first)
    else $error("wrong tick spacing at ratio 1:5");
  AST_T1_STROBE: assert property (tick_first |=> !tick_first [*5])
    else $error("first tick not a single strobe per period");
  // Other ticks are single strobes too, shortest period is six steps
  AST_T2_STROBE: assert property (tick_second |=> !tick_second [*5])
    else $error("second tick not a single strobe per period");
  AST_T3_STROBE: assert property (tick_third |=> !tick_third [*5])
    else $error("third tick not a single strobe per period");
  AST_T4_STROBE: assert property (tick_fourth |=> !tick_fourth [*5])
    else $error("fourth tick not a single strobe per period");
  // Reference level moves only at the first and third ticks
  AST_REF_STEADY: assert property ($changed(reference_clock) |-> tick_first || tick_third)
    else $error("reference level moved off the first or third tick");
  AST_T1_REF_HIGH: assert property (tick_first |-> reference_clock)
    else $error("first tick while reference low");
  AST_T3_REF_LOW: assert property (tick_third |-> !reference_clock)
    else $error("third tick while reference high");
  AST_T2_REF_HIGH: assert property (tick_second |-> reference_clock)
    else $error("second tick in the low half");
  AST_T4_REF_LOW: assert property (tick_fourth |-> !reference_clock)
    else $error("fourth tick in the high half");

  // ****************************************
  // Remaining even ratios
  // ****************************************
  // Quarter and three-quarter placement at 1:6, 1:8 and 1:10
  AST_R6_SPACING: assert property (tick_first && ratio_active == MTG_RATIO_1_6 |->
      ##3 tick_second ##3 tick_third ##3 tick_fourth ##3 tick_first)
    else $error("wrong tick spacing at ratio 1:6");
  AST_R8_SPACING: assert property (tick_first && ratio_active == MTG_RATIO_1_8 |->
      ##4 tick_second ##4 tick_third ##4 tick_fourth ##4 tick_first)
    else $error("wrong tick spacing at ratio 1:8");
  AST_R10_SPACING: assert property (tick_first && ratio_active == MTG_RATIO_1_10 |->
      ##5 tick_second ##5 tick_third ##5 tick_fourth ##5 tick_first)
    else $error("wrong tick spacing at ratio 1:10");

  // ****************************************
  // Ratio handling, counter and reset
  // ****************************************
  // Ratio swaps only at a period start, so no period mixes two spacings
  AST_RATIO_AT_T1: assert property ($changed(ratio_active) |-> tick_first)
    else $error("ratio changed inside a period");
  // Only the six legal codes ever reach the active ratio
  AST_RATIO_LEGAL: assert property (ratio_active <= MTG_RATIO_1_10)
    else $error("illegal ratio code in force");
  // Counter never passes the final step of its period
  AST_CNT_RANGE: assert property (st_q.cnt <= pos_q.last)
    else $error("step counter beyond period end");
  // Cycle after reset shows a period start with all launched outputs cleared
  AST_RESET_STATE: assert property (!$past(rstn) |-> tick_first && reference_clock &&
      ratio_active == MTG_RATIO_RST && mc_q == '0 && sdram_q == '0 && bus_q == '0)
    else $error("reset state not shown after release");

  // ****************************************
  // Launched values
  // ****************************************
  // Outputs carry the inputs seen at the launching edge; the reset state
  // also shows a first tick, so the cycle just after reset is left out
  AST_BUS_LAUNCH: assert property (tick_first && $past(rstn) |-> bus_q == $past(bus_d))
    else $error("bus output not launched from its input");
  AST_SDRAM_LAUNCH: assert property (tick_first && $past(rstn) |-> sdram_q == $past(sdram_d))
    else $error("sdram output not launched from its input");
  // Between ticks no programmable output may move
  AST_MC_QUIET: assert property (!(tick_first || tick_second || tick_third || tick_fourth) |->
      $stable(mc_q))
    else $error("programmable output moved between ticks");

  // ****************************************
  // Programmable outputs
  // ****************************************
  // Programmable output moves only on the tick it selected
  for (genvar g = 0; g < MTG_MC_SIGS; g++)
  begin : g_mc_chk
    AST_MC_ON_SEL: assert property ($changed(mc_q[g]) |->
        st_q.ticks[$past(mc_sel[g])])
      else $error("programmable output changed off its tick");
    AST_MC_LAUNCH: assert property (st_q.ticks[$past(mc_sel[g])] && $past(rstn) |->
        mc_q[g] == $past(mc_d[g]))
      else $error("programmable output not launched from its input");
  end

endmodule : mtg_tick_gen

// >>> dv/mtg_mem_model.sv
// Far-side memory model: latches bus outputs launched on the first tick
`timescale 1ns/1ps
module mtg_mem_model
  import mtg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic tick_first,
  input wire logic [MTG_BUS_W-1:0] bus_q,
  output logic [MTG_BUS_W-1:0] seen
);
  // Capture what the device launched at the rising reference edge
  always_ff @(posedge ref_clk)
  begin
    if (tick_first)
      seen <= bus_q;
  end
endmodule : mtg_mem_model

// >>> dv/mtg_tick_gen_tb.sv
// Self-checking testbench for the memory controller tick generator
`timescale 1ns/1ps
module mtg_tick_gen_tb
  import mtg_pkg::*;
;
  logic ref_clk, rstn, t1, t2, t3, t4, rc;
  logic [2:0] ratio_sel, ratio_active;
  mtg_mc_sel_t mc_sel;
  logic [3:0] mc_d, mc_q;
  logic [7:0] sdram_d, sdram_q, bus_d, bus_q, seen;
  int n_fail, n_compared;
  // ****************************************
  // Clock, design and far-side model
  // ****************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  mtg_tick_gen DUT (.ref_clk(ref_clk), .rstn(rstn), .ratio_sel(ratio_sel), .mc_sel(mc_sel), .mc_d(mc_d),
    .sdram_d(sdram_d), .bus_d(bus_d), .tick_first(t1), .tick_second(t2), .tick_third(t3), .tick_fourth(t4),
    .reference_clock(rc), .ratio_active(ratio_active), .mc_q(mc_q), .sdram_q(sdram_q), .bus_q(bus_q));
  mtg_mem_model PEER (.ref_clk(ref_clk), .tick_first(t1), .bus_q(bus_q), .seen(seen));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Wait at falling edges for a first tick, bounded
  task automatic wait_first;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge ref_clk);
      if (t1 === 1'b1)
        return;
    end
    n_fail++;
    wrap_up();
  endtask : wait_first
  // One period at a ratio: tick pattern, reference level, launched data
  task automatic measure(input logic [2:0] code, input int n, input int e2, input int e4, input logic [2:0] ea);
    logic [7:0] v;
    logic [4:0] e;
    v = 8'(n * 17);
    ratio_sel = code;
    bus_d = v;
    sdram_d = v;
    mc_d = 4'h5;
    wait_first();
    wait_first();
    chk(8'(ratio_active), 8'(ea));
    // New values right after the first tick; at 1:3 the second tick follows at once
    bus_d = ~v;
    sdram_d = ~v;
    mc_d = 4'ha;
    for (int c = 1; c <= 2 * n; c++)
    begin
      @(negedge ref_clk);
      e = {(c < n) || (c == 2 * n), c == e4, c == n, c == e2, c == 2 * n};
      chk(8'({rc, t4, t3, t2, t1}), 8'(e));
      if (c == 2 * n - 1)
      begin
        chk(8'(mc_q), 8'h0b);
        chk(sdram_q, v);
        chk(bus_q, v);
        chk(seen, v);
      end
    end
    chk(sdram_q, ~v);
  endtask : measure
  // Reset in mid-run: reset state, then one 1:4 period before the new ratio is taken
  task automatic reset_mid;
    rstn = 1'b0;
    ratio_sel = MTG_RATIO_1_5;
    bus_d = 8'h3c;
    sdram_d = 8'h3c;
    mc_d = 4'hf;
    repeat (2) @(negedge ref_clk);
    chk(8'({rc, t4, t3, t2, t1}), 8'h11);
    chk(8'(ratio_active), 8'(MTG_RATIO_1_4));
    chk(8'(mc_q), 8'h00);
    chk(sdram_q, 8'h00);
    chk(bus_q, 8'h00);
    rstn = 1'b1;
    for (int c = 1; c <= 8; c++)
    begin
      @(negedge ref_clk);
      chk(8'({rc, t4, t3, t2, t1}), 8'({c < 4 || c == 8, c == 6, c == 4, c == 2, c == 8}));
      if (c == 7)
      begin
        chk(8'(mc_q), 8'h0e);
        chk(bus_q, 8'h00);
      end
    end
    chk(8'(ratio_active), 8'(MTG_RATIO_1_5));
    chk(bus_q, 8'h3c);
    chk(sdram_q, 8'h3c);
    chk(8'(mc_q), 8'h0f);
  endtask : reset_mid
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    rstn = 1'b0;
    ratio_sel = MTG_RATIO_1_4;
    mc_sel = {2'h3, 2'h2, 2'h1, 2'h0};
    mc_d = 4'h0;
    sdram_d = 8'h00;
    bus_d = 8'h00;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    measure(MTG_RATIO_1_4, 4, 2, 6, MTG_RATIO_1_4);
    measure(MTG_RATIO_1_3, 3, 1, 4, MTG_RATIO_1_3);
    measure(MTG_RATIO_1_5, 5, 2, 7, MTG_RATIO_1_5);
    measure(MTG_RATIO_1_6, 6, 3, 9, MTG_RATIO_1_6);
    measure(MTG_RATIO_1_8, 8, 4, 12, MTG_RATIO_1_8);
    measure(MTG_RATIO_1_10, 10, 5, 15, MTG_RATIO_1_10);
    measure(3'h6, 10, 5, 15, MTG_RATIO_1_10);
    reset_mid();
    measure(MTG_RATIO_1_3, 3, 1, 4, MTG_RATIO_1_3);
    wrap_up();
  end
endmodule : mtg_tick_gen_tb
